// *** common/bwt_pkg.sv ***
// shared constants and types of the block word transfer engine
package bwt_pkg;

	// ************************************************************
	// register offsets on the plain register port
	// ************************************************************
	localparam logic [3:0]  REG_CTRL       = 4'h0;
	localparam logic [3:0]  REG_FLAGS      = 4'h1;
	localparam logic [3:0]  REG_IRQ_STAT   = 4'h2;
	localparam logic [3:0]  REG_IRQ_EN     = 4'h3;
	localparam logic [3:0]  REG_IRQ_CLR    = 4'h4;
	localparam logic [3:0]  REG_AREA       = 4'h5;
	localparam logic [3:0]  REG_BASE       = 4'h6;
	localparam logic [3:0]  REG_DONE_CNT   = 4'h7;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int          CTRL_TX_BIT    = 11;
	localparam int          CTRL_RX_BIT    = 12;
	localparam int          CTRL_INTEL_BIT = 13;
	localparam int          CTRL_POS_BIT   = 14;
	localparam logic [15:0] CTRL_WR_MASK   = 16'h7800;
	localparam logic [15:0] CTRL_RST       = 16'h0000;
	localparam int          FLG_TX_DONE    = 6;
	localparam int          FLG_TX_ERR     = 7;
	localparam int          FLG_RX_DONE    = 8;
	localparam int          FLG_RX_ERR     = 9;
	localparam int          IRQ_TX_DONE    = 0;
	localparam int          IRQ_TX_ERR     = 1;
	localparam int          IRQ_RX_DONE    = 2;
	localparam int          IRQ_RX_ERR     = 3;
	localparam logic [3:0]  IRQ_RST        = 4'h0;
	localparam logic [15:0] AREA_RST       = 16'h000D;
	localparam logic [15:0] BASE_RST       = 16'h0000;

	// ************************************************************
	// configuration, descriptor and transfer limits
	// ************************************************************
	localparam logic [15:0] CFG_AREA_DM    = 16'h000D;
	localparam logic [15:0] INIT_AREA_ADDR = 16'h0064;
	localparam logic [15:0] TX_DESC_OFS    = 16'h0000;
	localparam logic [15:0] RX_DESC_OFS    = 16'h0003;
	localparam int          BLOCK_WORDS    = 20;
	localparam logic [15:0] IO_MAX_WORDS   = 16'h1770;
	localparam logic [15:0] INTEL_MAX_WORDS = 16'h0080;
	localparam logic [15:0] INTEL_MAX_ITEMS = 16'h002A;
	localparam logic [15:0] POS_ITEM_WORDS = 16'h0003;
	localparam logic [1:0]  POS_LAST_SLOT  = 2'h2;
	localparam logic [1:0]  PAR_LAST_SLOT  = 2'h1;
	localparam logic [15:0] MAX_PLACES     = 16'h0009;
	localparam logic [3:0]  NEG_NIBBLE     = 4'hB;

	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_DESC0 = 4'h1,
		S_DESC1 = 4'h3,
		S_DESC2 = 4'h2,
		S_FETCH = 4'h6,
		S_CHECK = 4'h7,
		S_MOVE  = 4'h5,
		S_DONE  = 4'h4,
		S_ERR   = 4'hC,
		S_CFG_A = 4'hD,
		S_CFG_B = 4'hF
	} bwt_state_e;

endpackage

// *** common/bwt_store_if.sv ***
// word port between the engine and its unit-side data store
`timescale 1ns/10ps
`default_nettype none
interface bwt_store_if #(parameter int AW = 11);
	logic [AW-1:0] addr;
	logic          we;
	logic [15:0]   wdata;
	logic [15:0]   rdata;
	modport master (output addr, output we, output wdata, input rdata);
	modport slave  (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// *** rtl/bwt_store.sv ***
// unit-side data store: position and parameter words, one-cycle read
`timescale 1ns/10ps
`default_nettype none
module bwt_store #(
	parameter int AW = 11
) (
	input  wire logic   sys_clk_in,
	bwt_store_if.slave  port
);
	logic [15:0] mem [2**AW];

	always_ff @(posedge sys_clk_in) begin
		if (port.we) begin
			mem[port.addr] <= port.wdata;
		end
		port.rdata <= mem[port.addr];
	end
endmodule
`default_nettype wire

// *** rtl/bwt_item_check.sv ***
// validation of one word by its slot inside a position item, or as a plain BCD word inside a parameter item
`timescale 1ns/10ps
`default_nettype none
module bwt_item_check import bwt_pkg::*; (
	input  wire logic [15:0] word_in,
	input  wire logic        pos_in,
	input  wire logic [1:0]  slot_in,
	output logic             ok_out
);
	function automatic logic nib_ok(input logic [3:0] n);
		return n <= 4'h9;
	endfunction

	function automatic logic low3_ok(input logic [15:0] w);
		return nib_ok(w[3:0]) & nib_ok(w[7:4]) & nib_ok(w[11:8]);
	endfunction

	wire logic all_bcd  = low3_ok(word_in) & nib_ok(word_in[15:12]);
	// top nibble B marks a negative position
	wire logic high_ok  = low3_ok(word_in) & (nib_ok(word_in[15:12]) | (word_in[15:12] == NEG_NIBBLE));
	wire logic place_ok = word_in <= MAX_PLACES;
	wire logic pos_ok   = (slot_in == 2'h0) ? place_ok : ((slot_in == 2'h1) ? all_bcd : high_ok);

	// parameters are plain BCD words, low word first
	assign ok_out = pos_in ? pos_ok : all_bcd;
endmodule
`default_nettype wire

// *** rtl/bwt_engine.sv ***
// block word transfer engine: descriptor fetch, block move, check, flags
`timescale 1ns/10ps
`default_nettype none

// How it works
// - host loads count, source, destination, then raises control bit 11 to start.
// - after all data moved and checked, completion flag bit 6 is set.
// - on control bit, three descriptor words are read before any payload.
// - payload fetched in blocks of at most twenty words, repeated.
// - each fetched block is validated before the next fetch.
// - single-instruction mode caps a request at 128 words or 42 items.
// - area word 000D selects data memory; next word is area start.
// - configuration words are read only after reset, i.e. power cycle.
// - position item is three words: places, low BCD, high BCD sign B.
// - parameter item is two BCD words, low word first.
// - completion flag clears when the host drops its control bit.
// - a failed transfer raises the error flag instead of completion.
module bwt_engine import bwt_pkg::*; #(
	parameter logic [15:0] INIT_ADDR = INIT_AREA_ADDR,
	parameter int          STORE_AW  = 11
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic [3:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic [15:0]      reg_rdata_out,
	output logic             mem_rd_out,
	output logic             mem_wr_out,
	output logic             mem_ext_out,
	output logic [15:0]      mem_addr_out,
	output logic [15:0]      mem_wdata_out,
	input  wire logic [15:0] mem_rdata_in,
	output logic             irq_out
);

	// ************************************************************
	// state
	// ************************************************************
	bwt_state_e  state;
	bwt_state_e  next_state;
	logic        ph;
	logic        rx;
	logic        intel_q;
	logic        pos_q;
	logic [15:0] area;
	logic [15:0] base;
	logic [15:0] cnt;
	logic [15:0] src;
	logic [15:0] dst;
	logic [15:0] done_n;
	logic [4:0]  idx;
	logic [1:0]  slot;
	logic [15:0] buf_q [BLOCK_WORDS];
	logic [15:0] ctrl;
	logic        tx_done;
	logic        tx_err;
	logic        rx_done;
	logic        rx_err;
	logic [3:0]  irq_stat;
	logic [3:0]  irq_en;
	logic        chk_ok;

	bwt_store_if #(.AW(STORE_AW)) st ();

	// ************************************************************
	// decoding
	// ************************************************************
	wire logic in_desc  = (state == S_DESC0) | (state == S_DESC1) | (state == S_DESC2);
	wire logic in_cfg   = (state == S_CFG_A) | (state == S_CFG_B);
	wire logic rd_state = in_cfg | in_desc | (state == S_FETCH);

	// start only from rest and only once per raising of the bit
	wire logic tx_go = (state == S_IDLE) & ctrl[CTRL_TX_BIT] & ~tx_done & ~tx_err;
	wire logic rx_go = (state == S_IDLE) & ctrl[CTRL_RX_BIT] & ~rx_done & ~rx_err & ~tx_go;
	wire logic go    = tx_go | rx_go;

	wire logic [15:0] remain  = cnt - done_n;
	// blocks are capped at twenty words
	wire logic [4:0]  blk_len = (remain > 16'(BLOCK_WORDS)) ? 5'(BLOCK_WORDS) : remain[4:0];
	wire logic        last_idx = (idx == blk_len - 5'h1);
	wire logic        last_blk = ((done_n + 16'(blk_len)) == cnt);
	wire logic [1:0]  last_slot = pos_q ? POS_LAST_SLOT : PAR_LAST_SLOT;

	wire logic [15:0] limit = intel_q ?
		(pos_q ? 16'(INTEL_MAX_ITEMS * POS_ITEM_WORDS) : INTEL_MAX_WORDS) : IO_MAX_WORDS;
	wire logic        bad_cnt = (cnt == 16'h0000) | (cnt > limit);

	wire logic [15:0] desc_ofs = rx ? RX_DESC_OFS : TX_DESC_OFS;
	wire logic [15:0] desc_k   = (state == S_DESC0) ? 16'h0000 : ((state == S_DESC1) ? 16'h0001 : 16'h0002);
	wire logic [15:0] xfer_adr = ((state == S_MOVE) ? dst : src) + done_n + 16'(idx);
	wire logic [15:0] rd_adr   = (state == S_CFG_A) ? INIT_ADDR :
		((state == S_CFG_B) ? INIT_ADDR + 16'h0001 : (in_desc ? base + desc_ofs + desc_k : xfer_adr));

	// read data from whichever side is the source this cycle
	wire logic [15:0] rdv = (rx & (state == S_FETCH)) ? st.rdata : mem_rdata_in;

	wire logic step = ((state == S_FETCH) & ph) | (state == S_CHECK) | (state == S_MOVE);

	// ************************************************************
	// host data area and unit store ports
	// ************************************************************
	assign mem_rd_out    = ~ph & (in_cfg | in_desc | ((state == S_FETCH) & ~rx));
	assign mem_wr_out    = (state == S_MOVE) & rx;
	assign mem_addr_out  = (state == S_MOVE) ? xfer_adr : rd_adr;
	assign mem_wdata_out = buf_q[idx];
	// 000D keeps the expansion area in data memory, others in extended memory
	assign mem_ext_out   = mem_rd_out & in_desc & (area != CFG_AREA_DM);

	assign st.addr  = xfer_adr[STORE_AW-1:0];
	assign st.we    = (state == S_MOVE) & ~rx;
	assign st.wdata = buf_q[idx];

	bwt_store #(.AW(STORE_AW)) u_store (
		.sys_clk_in (sys_clk_in),
		.port       (st.slave)
	);

	bwt_item_check u_chk (
		.word_in (buf_q[idx]),
		.pos_in  (pos_q),
		.slot_in (slot),
		.ok_out  (chk_ok)
	);

	// ************************************************************
	// sequencer
	// ************************************************************
	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (go) begin
					next_state = S_DESC0;
				end
			end
			S_CFG_A: begin
				if (ph) begin
					next_state = S_CFG_B;
				end
			end
			S_CFG_B: begin
				if (ph) begin
					next_state = S_IDLE;
				end
			end
			S_DESC0: begin
				if (ph) begin
					next_state = S_DESC1;
				end
			end
			S_DESC1: begin
				if (ph) begin
					next_state = S_DESC2;
				end
			end
			S_DESC2: begin
				if (ph) begin
					next_state = bad_cnt ? S_ERR : S_FETCH;
				end
			end
			S_FETCH: begin
				if (ph & last_idx) begin
					next_state = S_CHECK;
				end
			end
			S_CHECK: begin
				if (~chk_ok) begin
					next_state = S_ERR;
				end else if (last_idx) begin
					next_state = S_MOVE;
				end
			end
			S_MOVE: begin
				if (last_idx & ~last_blk) begin
					next_state = S_FETCH;
				end else if (last_idx) begin
					// a partial item at the end is a broken transfer
					next_state = (slot == 2'h0) ? S_DONE : S_ERR;
				end
			end
			S_DONE: begin
				next_state = S_IDLE;
			end
			S_ERR: begin
				next_state = S_IDLE;
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	// configuration is fetched only on leaving reset, never while running
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state <= S_CFG_A;
			ph    <= 1'b0;
			area  <= AREA_RST;
			base  <= BASE_RST;
		end else begin
			state <= next_state;
			ph    <= rd_state & ~ph;
			if (ph & (state == S_CFG_A)) begin
				area <= rdv;
			end
			if (ph & (state == S_CFG_B)) begin
				base <= rdv;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			rx      <= 1'b0;
			intel_q <= 1'b0;
			pos_q   <= 1'b0;
			cnt     <= 16'h0000;
			src     <= 16'h0000;
			dst     <= 16'h0000;
		end else if (go) begin
			rx      <= ~tx_go;
			intel_q <= ctrl[CTRL_INTEL_BIT];
			pos_q   <= ctrl[CTRL_POS_BIT];
		end else if (ph) begin
			cnt <= (state == S_DESC0) ? rdv : cnt;
			src <= (state == S_DESC1) ? rdv : src;
			dst <= (state == S_DESC2) ? rdv : dst;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in | go) begin
			idx    <= 5'h00;
			slot   <= 2'h0;
			done_n <= 16'h0000;
		end else begin
			idx <= (step & last_idx) ? 5'h00 : idx + 5'(step);
			if (state == S_CHECK) begin
				slot <= (slot == last_slot) ? 2'h0 : slot + 2'h1;
			end
			if ((state == S_MOVE) & last_idx) begin
				done_n <= done_n + 16'(blk_len);
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if ((state == S_FETCH) & ph) begin
			buf_q[idx] <= rdv;
		end
	end

	// ************************************************************
	// flags: a set in the same cycle as the drop wins
	// ************************************************************
	wire logic ev_tx_done = (state == S_DONE) & ~rx;
	wire logic ev_tx_err  = (state == S_ERR) & ~rx;
	wire logic ev_rx_done = (state == S_DONE) & rx;
	wire logic ev_rx_err  = (state == S_ERR) & rx;
	wire logic [3:0] ev   = {ev_rx_err, ev_rx_done, ev_tx_err, ev_tx_done};

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			tx_done <= 1'b0;
			tx_err  <= 1'b0;
			rx_done <= 1'b0;
			rx_err  <= 1'b0;
		end else begin
			tx_done <= ev_tx_done | (tx_done & ctrl[CTRL_TX_BIT]);
			tx_err  <= ev_tx_err | (tx_err & ctrl[CTRL_TX_BIT]);
			rx_done <= ev_rx_done | (rx_done & ctrl[CTRL_RX_BIT]);
			rx_err  <= ev_rx_err | (rx_err & ctrl[CTRL_RX_BIT]);
		end
	end

	// ************************************************************
	// register port and interrupt
	// ************************************************************
	wire logic wr_ctrl = reg_wr_in & (reg_addr_in == REG_CTRL);
	wire logic wr_en   = reg_wr_in & (reg_addr_in == REG_IRQ_EN);
	wire logic wr_clr  = reg_wr_in & (reg_addr_in == REG_IRQ_CLR);

	wire logic [15:0] flags = (16'(tx_done) << FLG_TX_DONE) | (16'(tx_err) << FLG_TX_ERR) |
		(16'(rx_done) << FLG_RX_DONE) | (16'(rx_err) << FLG_RX_ERR);

	wire logic [15:0] rd_mux =
		(reg_addr_in == REG_CTRL)     ? ctrl :
		(reg_addr_in == REG_FLAGS)    ? flags :
		(reg_addr_in == REG_IRQ_STAT) ? {12'h000, irq_stat} :
		(reg_addr_in == REG_IRQ_EN)   ? {12'h000, irq_en} :
		(reg_addr_in == REG_AREA)     ? area :
		(reg_addr_in == REG_BASE)     ? base :
		(reg_addr_in == REG_DONE_CNT) ? done_n : 16'h0000;

	assign irq_out = |(irq_stat & irq_en);

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ctrl          <= CTRL_RST;
			irq_en        <= IRQ_RST;
			irq_stat      <= IRQ_RST;
			reg_rdata_out <= 16'h0000;
		end else begin
			ctrl          <= wr_ctrl ? (reg_wdata_in & CTRL_WR_MASK) : ctrl;
			irq_en        <= wr_en ? reg_wdata_in[3:0] : irq_en;
			irq_stat      <= ev | (irq_stat & ~(wr_clr ? reg_wdata_in[3:0] : 4'h0));
			reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0000;
		end
	end

endmodule
`default_nettype wire

// *** dv/bwt_engine_properties.sv ***
// concurrent checks on the transfer engine ports
`timescale 1ns/10ps
`default_nettype none
module bwt_engine_properties import bwt_pkg::*; (
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	input wire logic [3:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic        mem_rd_out,
	input wire logic        mem_wr_out,
	input wire logic        mem_ext_out,
	input wire logic [15:0] mem_addr_out,
	input wire logic        irq_out
);
	logic       rst_d;
	default clocking cb @(posedge sys_clk_in); endclocking
	// the edge of release still samples reset-time outputs, so stay off one edge longer
	default disable iff (rst_in || rst_d);
	logic       rd_d1;
	logic       rd_d2;
	logic [5:0] run_len;
	wire        ctrl_wr = reg_wr_in && reg_addr_in == REG_CTRL;
	wire        go_wr   = ctrl_wr && (reg_wdata_in[CTRL_TX_BIT] || reg_wdata_in[CTRL_RX_BIT]);
	always_ff @(posedge sys_clk_in) begin
		rst_d <= rst_in;
	end
	// ********************
	// run of reads spaced two cycles apart; descriptor plus one block is the longest legal run
	// ********************
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			rd_d1 <= 1'b0;
			rd_d2 <= 1'b0;
			run_len <= 6'h00;
		end else begin
			rd_d1 <= mem_rd_out;
			rd_d2 <= rd_d1;
			if (mem_rd_out) begin
				run_len <= rd_d2 ? run_len + 6'h01 : 6'h01;
			end
		end
	end
	property p_rd_gap; mem_rd_out |=> !mem_rd_out; endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("host reads not spaced");
	property p_block; run_len <= 6'h17; endproperty
	a_block: assert property (p_block) else $error("block longer than twenty words");
	property p_start; go_wr |-> ##[1:4] mem_rd_out; endproperty
	a_start: assert property (p_start) else $error("control bit did not start a fetch");
	property p_desc;
		go_wr ##2 mem_rd_out |-> ##2 (mem_rd_out && mem_addr_out == $past(mem_addr_out, 2) + 16'h0001)
			##2 (mem_rd_out && mem_addr_out == $past(mem_addr_out, 2) + 16'h0001);
	endproperty
	a_desc: assert property (p_desc) else $error("descriptor words not read in order");
	property p_excl; !(mem_rd_out && mem_wr_out); endproperty
	a_excl: assert property (p_excl) else $error("host read and write together");
	property p_ext; mem_ext_out |-> mem_rd_out; endproperty
	a_ext: assert property (p_ext) else $error("region select outside a read");
	property p_rdz; !reg_rd_in |=> reg_rdata_out == 16'h0000; endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside its cycle");
	property p_irq_off; reg_wr_in && reg_addr_in == REG_IRQ_EN && reg_wdata_in[3:0] == 4'h0 |=> !irq_out; endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt while all masked");
	property p_irq_clr;
		reg_wr_in && reg_addr_in == REG_IRQ_CLR && reg_wdata_in[3:0] == 4'hF && !mem_rd_out && !mem_wr_out |=> !irq_out;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("interrupt survived a full clear");
	property p_drop;
		ctrl_wr && !reg_wdata_in[CTRL_TX_BIT] ##2 reg_rd_in && reg_addr_in == REG_FLAGS |=> !reg_rdata_out[FLG_TX_DONE];
	endproperty
	a_drop: assert property (p_drop) else $error("done flag kept after control drop");
	c_wr: cover property (mem_wr_out);
	c_full: cover property (run_len == 6'h17);
	c_irq: cover property (irq_out);
endmodule
bind bwt_engine bwt_engine_properties u_props (
	.sys_clk_in   (sys_clk_in),
	.rst_in       (rst_in),
	.reg_addr_in  (reg_addr_in),
	.reg_wdata_in (reg_wdata_in),
	.reg_wr_in    (reg_wr_in),
	.reg_rd_in    (reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.mem_rd_out   (mem_rd_out),
	.mem_wr_out   (mem_wr_out),
	.mem_ext_out  (mem_ext_out),
	.mem_addr_out (mem_addr_out),
	.irq_out      (irq_out)
);
`default_nettype wire

// *** dv/bwt_host_mem.sv ***
// host data area model: one-cycle read answer, released bus shows inverted data
`timescale 1ns/10ps
`default_nettype none
module bwt_host_mem (
	input  wire logic        sys_clk_in,
	input  wire logic        mem_rd_in,
	input  wire logic        mem_wr_in,
	input  wire logic [15:0] mem_addr_in,
	input  wire logic [15:0] mem_wdata_in,
	output logic [15:0]      mem_rdata_out
);
	logic [15:0] mem [0:1023];
	initial begin
		mem_rdata_out = 16'h0000;
		for (int i = 0; i < 1024; i++) begin
			mem[i] = 16'h0000;
		end
	end
	// the bench preloads words by hierarchy, so this stays a plain always block
	always @(posedge sys_clk_in) begin
		if (mem_rd_in) begin
			mem_rdata_out <= mem[mem_addr_in[9:0]];
		end else begin
			mem_rdata_out <= ~mem_rdata_out;
		end
		if (mem_wr_in) begin
			mem[mem_addr_in[9:0]] <= mem_wdata_in;
		end
	end
endmodule
`default_nettype wire

// *** dv/test_block_word_transfer_engine.sv ***
// self-checking bench of the block word transfer engine
`timescale 1ns/10ps
`default_nettype none
module test_block_word_transfer_engine import bwt_pkg::*; ();
	logic        sys_clk_in   = 1'b0;
	logic        rst_in       = 1'b1;
	logic [3:0]  reg_addr_in  = 4'h0;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic        reg_wr_in    = 1'b0;
	logic        reg_rd_in    = 1'b0;
	logic [15:0] reg_rdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
	logic        mem_rd_out, mem_wr_out, mem_ext_out, irq_out;
	int          n_fail       = 0;
	int          n_checks     = 0;
	int          n_cyc        = 0;
	int          n_ext        = 0;
	localparam logic [15:0] POS [15] = '{16'h0002, 16'h7890, 16'h3456, 16'h0002, 16'h5678, 16'h1234, 16'h0002,
		16'h5432, 16'hB876, 16'h0003, 16'h3456, 16'h0012, 16'h0002, 16'h2100, 16'h0543};
	always #20 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) begin
		if (mem_ext_out) begin
			n_ext++;
		end
	end
	bwt_engine #(.INIT_ADDR(INIT_AREA_ADDR), .STORE_AW(11)) u_dut (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .mem_rd_out(mem_rd_out),
		.mem_wr_out(mem_wr_out), .mem_ext_out(mem_ext_out), .mem_addr_out(mem_addr_out),
		.mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in), .irq_out(irq_out));
	bwt_host_mem u_host (.sys_clk_in(sys_clk_in), .mem_rd_in(mem_rd_out), .mem_wr_in(mem_wr_out),
		.mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in));
	// ********************
	// bus and compare helpers
	// ********************
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
		@(posedge sys_clk_in);
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one transfer: descriptor, start, wait for the event, then drop the control bit
	task automatic run(input logic [63:0] t, input int ib);
		logic [15:0] v;
		logic [9:0]  o;
		o = t[60] ? 10'h203 : 10'h200;
		v = 16'h0000;
		u_host.mem[o] = t[47:32];
		u_host.mem[o + 10'h001] = t[31:16];
		u_host.mem[o + 10'h002] = t[15:0];
		wr(REG_IRQ_CLR, 16'h000F);
		wr(REG_CTRL, t[63:48]);
		for (int i = 0; i < 600 && v == 16'h0000; i++) begin
			rd(REG_IRQ_STAT, v);
		end
		chk("irq_stat", 16'h0001 << ib, v);
		chk("irq_out", {15'h0000, ib == 0}, {15'h0000, irq_out});
		rd(REG_FLAGS, v);
		chk("flags", 16'h0040 << ib, v & 16'h03C0);
		wr(REG_CTRL, 16'h0000);
		rd(REG_FLAGS, v);
		chk("flags_off", 16'h0000, v & 16'h0140);
	endtask
	// ********************
	// scenarios
	// ********************
	task automatic t_reset();
		logic [15:0] v;
		logic [3:0]  a [7] = '{REG_CTRL, REG_FLAGS, REG_IRQ_STAT, REG_IRQ_EN, REG_AREA, REG_BASE, 4'h8};
		logic [15:0] e [7] = '{CTRL_RST, 16'h0000, 16'h0000, 16'h0000, CFG_AREA_DM, 16'h0200, 16'h0000};
		wr(REG_FLAGS, 16'hFFFF);
		wr(4'h8, 16'hFFFF);
		// changed once the engine has taken it: must not be adopted before the next reset
		u_host.mem[10'h065] = 16'h0777;
		for (int i = 0; i < 7; i++) begin
			rd(a[i], v);
			chk("reg", e[i], v);
		end
		wr(REG_IRQ_EN, 16'h0000);
		wr(REG_IRQ_EN, 16'h0001);
		$display("test reset done");
	endtask
	task automatic t_param();
		logic [15:0] v;
		run({16'h0800, 16'h0002, 16'h0300, 16'h0010}, IRQ_TX_DONE);
		rd(REG_DONE_CNT, v);
		chk("done_cnt", 16'h0002, v);
		wr(REG_IRQ_CLR, 16'h000F);
		chk("irq_clr", 16'h0000, {15'h0000, irq_out});
		run({16'h1000, 16'h0002, 16'h0010, 16'h0080}, IRQ_RX_DONE);
		chk("rx_lo", 16'h0500, u_host.mem[10'h080]);
		chk("rx_hi", 16'h0000, u_host.mem[10'h081]);
		$display("test param done");
	endtask
	task automatic t_pos();
		run({16'h4800, 16'h0018, 16'h0340, 16'h0020}, IRQ_TX_DONE);
		run({16'h5000, 16'h0018, 16'h0020, 16'h0100}, IRQ_RX_DONE);
		for (int i = 0; i < 24; i++) begin
			chk("rx_pos", POS[i % 15], u_host.mem[10'h100 + i]);
		end
		$display("test position done");
	endtask
	task automatic t_err();
		logic [63:0] t [6] = '{64'h2800_0080_0380_0100, 64'h2800_0081_0380_0100, 64'h6800_0081_0380_0100,
			64'h0800_0000_0380_0100, 64'h4800_0004_0380_0100, 64'h4800_0003_0330_0100};
		for (int i = 0; i < 6; i++) begin
			run(t[i], i == 0 ? IRQ_TX_DONE : IRQ_TX_ERR);
		end
		$display("test error done");
	endtask
	// second reset stands in for a power cycle: new area word is adopted only now
	task automatic t_cfg();
		logic [15:0] v;
		chk("ext_dm", 16'h0000, 16'(n_ext));
		u_host.mem[10'h064] = 16'h0001;
		u_host.mem[10'h065] = 16'h0200;
		rst_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		repeat (6) @(posedge sys_clk_in);
		rd(REG_AREA, v);
		chk("area_new", 16'h0001, v);
		wr(REG_IRQ_EN, 16'h0001);
		run({16'h0800, 16'h0002, 16'h0300, 16'h0010}, IRQ_TX_DONE);
		chk("ext_em", 16'h0003, 16'(n_ext));
		$display("test config done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// transfers here take about a thousand cycles in all; the ceiling leaves ample margin
	always @(posedge sys_clk_in) begin
		n_cyc++;
		if (n_cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		#1;
		u_host.mem[10'h064] = CFG_AREA_DM;
		u_host.mem[10'h065] = 16'h0200;
		u_host.mem[10'h300] = 16'h0500;
		u_host.mem[10'h081] = 16'hFFFF;
		u_host.mem[10'h330] = 16'h000A;
		for (int i = 0; i < 24; i++) begin
			u_host.mem[10'h340 + i] = POS[i % 15];
		end
		repeat (2) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		@(posedge sys_clk_in);
		t_reset();
		t_param();
		t_pos();
		t_err();
		t_cfg();
		summarize();
	end
endmodule
`default_nettype wire
